// >>> rtl/sdr_ctrl_end.sv
/*
  Controller end of the SDRAM pin interface and its write-data FIFO.
  Assumes the memory end shares sys_clk; single-word accesses with
  autoprecharge, burst length one and CAS latency two.
*/
`timescale 1ns/100ps
`default_nettype none
module sdr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic inReady;
    logic outValid;
  } sdr_fifo_s;

  sdr_fifo_s q;
  sdr_fifo_s d;
  logic [W-1:0] store [0:DEPTH-1];
  logic push;
  logic pop;

  always_comb begin
    d = q;
    push = inValid && q.inReady;
    pop = outReady && q.outValid;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
    d.inReady = (d.count != (AW+1)'(DEPTH));
    d.outValid = (d.count != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[q.wp] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.inReady <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign inReady = q.inReady;
  assign outValid = q.outValid;
  assign outData = store[q.rp];
endmodule // sdr_fifo

module sdr_ctrl_end
  import sdr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  sdr_pin_if.ctrl pins,
  input wire logic sleepReq,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [BA_W-1:0] cmdBank,
  input wire logic [ADDR_W-1:0] cmdRow,
  input wire logic [COL_W-1:0] cmdCol,
  input wire logic [LANES-1:0] cmdMask,
  input wire logic wrValid,
  input wire logic [DQ_W-1:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [DQ_W-1:0] rdData,
  output logic initDone
);
  typedef enum logic [3:0] {
    C_INIT = 4'h0, C_PRE_ALL = 4'h1, C_MRS = 4'h2, C_IDLE = 4'h3, C_SLEEP = 4'h4,
    C_ACT = 4'h5, C_READ_WAIT = 4'h6, C_RECOVER = 4'h7
  } sdr_ctl_e;

  typedef struct packed {
    sdr_ctl_e state;
    logic [TIMER_W-1:0] timer;
    logic cke;
    logic csN;
    logic [2:0] rcw;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] dqm;
    logic [DQ_W-1:0] dqOut;
    logic dqOeN;
    logic cmdReady;
    logic rdValid;
    logic [DQ_W-1:0] rdData;
    logic initDone;
    logic isWrite;
    logic [BA_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [LANES-1:0] mask;
  } sdr_ctl_s;

  sdr_ctl_s q;
  sdr_ctl_s d;
  logic fifoValid;
  logic [DQ_W-1:0] fifoData;
  logic fifoPop;

  sdr_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(wrValid),
    .inData(wrData),
    .inReady(wrReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    d = q;
    fifoPop = 1'b0;
    d.csN = 1'b1;
    d.rcw = PIN_NOP;
    d.dqm = '0;
    d.dqOeN = 1'b1;
    d.rdValid = 1'b0;
    d.cmdReady = 1'b0;
    if (q.timer != '0) begin
      d.timer = q.timer - 1'b1;
    end
    case (q.state)
      C_INIT: begin
        if (q.timer == '0) begin
          d.csN = 1'b0;
          d.rcw = PIN_PRE;
          d.addr = AP_MASK;
          d.timer = TIMER_W'(T_RP_CYC);
          d.state = C_PRE_ALL;
        end
      end
      C_PRE_ALL: begin
        if (q.timer == '0) begin
          d.csN = 1'b0;
          d.rcw = PIN_LMR;
          d.addr = CTRL_MODE_WORD;
          d.timer = TIMER_W'(T_MRD_CYC);
          d.state = C_MRS;
        end
      end
      C_MRS: begin
        if (q.timer == '0) begin
          d.initDone = 1'b1;
          d.cmdReady = 1'b1;
          d.state = C_IDLE;
        end
      end
      C_IDLE: begin
        if (sleepReq) begin
          d.cke = 1'b0;
          d.state = C_SLEEP;
        end else if (cmdValid && q.cmdReady && (!cmdWrite || fifoValid)) begin
          d.isWrite = cmdWrite;
          d.bank = cmdBank;
          d.col = cmdCol;
          d.mask = cmdMask;
          d.csN = 1'b0;
          d.rcw = PIN_ACT;
          d.ba = cmdBank;
          d.addr = cmdRow;
          d.timer = TIMER_W'(T_RCD_CYC);
          d.state = C_ACT;
        end else begin
          d.cmdReady = 1'b1;
        end
      end
      C_SLEEP: begin
        if (!sleepReq) begin
          d.cke = 1'b1;
          d.timer = TIMER_W'(T_XP_CYC);
          d.state = C_RECOVER;
        end
      end
      C_ACT: begin
        if (q.timer == '0) begin
          d.csN = 1'b0;
          d.rcw = q.isWrite ? PIN_WRITE : PIN_READ;
          d.ba = q.bank;
          d.addr = ADDR_W'(q.col) | AP_MASK;
          if (q.isWrite) begin
            d.dqm = q.mask;
            d.dqOut = fifoData;
            d.dqOeN = 1'b0;
            fifoPop = 1'b1;
            d.timer = TIMER_W'(T_WR_CYC + T_RP_CYC);
            d.state = C_RECOVER;
          end else begin
            d.timer = TIMER_W'(RD_TIMEOUT_CYC);
            d.state = C_READ_WAIT;
          end
        end
      end
      C_READ_WAIT: begin
        if (pins.dqMemOeN != '1) begin
          d.rdData = pins.dqMem;
          d.rdValid = 1'b1;
          d.timer = TIMER_W'(T_RP_CYC);
          d.state = C_RECOVER;
        end else if (q.timer == '0) begin
          d.state = C_RECOVER;
        end
      end
      C_RECOVER: begin
        if (q.timer == '0) begin
          d.cmdReady = 1'b1;
          d.state = C_IDLE;
        end
      end
      default: d.state = C_INIT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= C_INIT;
      q.timer <= TIMER_W'(T_INIT_CYC);
      q.cke <= 1'b1;
      q.csN <= 1'b1;
      q.rcw <= PIN_NOP;
      q.dqOeN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pins.cke = q.cke;
  assign pins.csN = q.csN;
  assign pins.rasN = q.rcw[2];
  assign pins.casN = q.rcw[1];
  assign pins.weN = q.rcw[0];
  assign pins.ba = q.ba;
  assign pins.addr = q.addr;
  assign pins.dqm = q.dqm;
  assign pins.dqCtrl = q.dqOut;
  assign pins.dqCtrlOeN = q.dqOeN;
  assign cmdReady = q.cmdReady;
  assign rdValid = q.rdValid;
  assign rdData = q.rdData;
  assign initDone = q.initDone;
endmodule // sdr_ctrl_end
`default_nettype wire

// >>> rtl/sdr_pkg.sv
/*
  Shared constants, command encodings and helpers for the SDRAM pin command
  interface, used by the memory end and the controller end.
  Assumes a single 20 MHz sys_clk shared by both ends.
*/
package sdr_pkg;
  // ==========================================================
  // Geometry, 32-bit configuration
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int BANKS = 4;
  localparam int ROWS_X32 = 4096;
  localparam int ROWS_X16 = 8192;
  localparam int COLS = 512;
  localparam int AP_BIT = 10;
  localparam logic [ADDR_W-1:0] AP_MASK = ADDR_W'(1 << AP_BIT);
  // Storage model depth: bank, low row bit, low column bits
  localparam int MEM_COL_W = 5;
  localparam int MEM_AW = BA_W + 1 + MEM_COL_W;

  // ==========================================================
  // Mode register op-code fields
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [ADDR_W-1:0] CTRL_MODE_WORD = ADDR_W'({CL_2, 1'b0, BL_1});

  // ==========================================================
  // Pin code {RAS#, CAS#, WE#}
  localparam logic [2:0] PIN_LMR = 3'h0;
  localparam logic [2:0] PIN_REF = 3'h1;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_WRITE = 3'h4;
  localparam logic [2:0] PIN_READ = 3'h5;
  localparam logic [2:0] PIN_BST = 3'h6;
  localparam logic [2:0] PIN_NOP = 3'h7;

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_READ = 4'h3, CMD_WRITE = 4'h4,
    CMD_PRE = 4'h5, CMD_REF = 4'h6, CMD_LMR = 4'h7, CMD_BST = 4'h8
  } sdr_cmd_e;

  typedef enum logic [2:0] {
    PWR_RUN = 3'h0, PWR_PDN_PRE = 3'h1, PWR_PDN_ACT = 3'h2, PWR_SELF_REF = 3'h3,
    PWR_DEEP_PD = 3'h4, PWR_SUSPEND = 3'h5
  } sdr_pwr_e;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RCD_NS = 18;
  localparam int T_RP_NS = 18;
  localparam int T_WR_NS = 15;
  localparam int T_INIT_US = 100;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_INIT_CYC = (T_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_MRD_CYC = 2;
  localparam int T_XP_CYC = 1;
  localparam int RD_TIMEOUT_CYC = 8;
  localparam int TIMER_W = 12;
  localparam int FIFO_DEPTH = 32;

  function automatic sdr_cmd_e cmd_decode(input logic csN, input logic [2:0] rcw);
    sdr_cmd_e c;
    c = CMD_INHIBIT;
    if (!csN) begin
      case (rcw)
        PIN_LMR: c = CMD_LMR;
        PIN_REF: c = CMD_REF;
        PIN_PRE: c = CMD_PRE;
        PIN_ACT: c = CMD_ACT;
        PIN_WRITE: c = CMD_WRITE;
        PIN_READ: c = CMD_READ;
        PIN_BST: c = CMD_BST;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Words remaining after the first, per burst length code
  function automatic logic [COL_W-1:0] burst_rest(input logic [2:0] bl);
    logic [COL_W-1:0] r;
    r = '0;
    case (bl)
      BL_2: r = COL_W'(1);
      BL_4: r = COL_W'(3);
      BL_8: r = COL_W'(7);
      BL_PAGE: r = COL_W'(COLS - 1);
      default: r = '0;
    endcase
    return r;
  endfunction
endpackage

// >>> rtl/sdr_pin_if.sv
/*
  Pin-level bundle between the SDRAM controller and the memory end.
  Assumes both ends share sys_clk; the data bus is split into two directed
  halves with active-low enables, each end reads the other end's half directly.
*/
`timescale 1ns/100ps
`default_nettype none
interface sdr_pin_if;
  import sdr_pkg::*;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] dqm;
  logic [DQ_W-1:0] dqCtrl;
  logic dqCtrlOeN;
  logic [DQ_W-1:0] dqMem;
  logic [LANES-1:0] dqMemOeN;

  modport mem (input cke, csN, rasN, casN, weN, ba, addr, dqm, dqCtrl, dqCtrlOeN,
               output dqMem, dqMemOeN);
  modport ctrl (output cke, csN, rasN, casN, weN, ba, addr, dqm, dqCtrl, dqCtrlOeN,
                input dqMem, dqMemOeN);
endinterface // sdr_pin_if
`default_nettype wire

// >>> rtl/sdr_mem_end.sv
/*
  Memory end of the SDRAM pin interface: input capture, command decode,
  power and suspend states, bank rows, bursts, byte masks and read pipeline.
  Assumes the controller end drives the pins from the same sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sdr_mem_end
  import sdr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  sdr_pin_if.mem pins,
  output logic [2:0] powerState,
  output logic [BANKS-1:0] openBanks
);

  typedef struct packed {
    logic cke;
    logic csN;
    logic [2:0] rcw;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] dqm;
    logic [DQ_W-1:0] dqIn;
    sdr_pwr_e pwr;
    logic [BANKS-1:0] rowOpen;
    logic [BANKS-1:0][ADDR_W-1:0] rowAddr;
    logic [ADDR_W-1:0] modeReg;
    logic burstOn;
    logic burstRead;
    logic burstAp;
    logic [BA_W-1:0] burstBank;
    logic [COL_W-1:0] burstCol;
    logic [COL_W-1:0] burstLeft;
    logic [2:0] pipeValid;
    logic [2:0][DQ_W-1:0] pipeData;
    logic [LANES-1:0] dqmDly;
    logic [DQ_W-1:0] dqOut;
    logic [LANES-1:0] dqOeN;
  } sdr_mem_s;

  sdr_mem_s q;
  sdr_mem_s d;

  // Reduced storage: only bank, row bit 0 and low column bits index it
  logic [DQ_W-1:0] mem [0:(1 << MEM_AW)-1];

  sdr_cmd_e cmd;
  logic opGo;
  logic opRead;
  logic [BA_W-1:0] opBank;
  logic [COL_W-1:0] opCol;
  logic [MEM_AW-1:0] opIdx;
  logic [DQ_W-1:0] memRd;
  logic lowPower;

  function automatic logic [MEM_AW-1:0] mem_index(input logic [BA_W-1:0] bank,
                                                  input logic [ADDR_W-1:0] row,
                                                  input logic [COL_W-1:0] col);
    return {bank, row[0], col[MEM_COL_W-1:0]};
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    d = q;
    opGo = 1'b0;
    opRead = 1'b0;
    opBank = q.burstBank;
    opCol = q.burstCol;
    lowPower = (q.pwr == PWR_PDN_PRE) || (q.pwr == PWR_PDN_ACT) ||
               (q.pwr == PWR_SELF_REF) || (q.pwr == PWR_DEEP_PD);
    cmd = cmd_decode(q.csN, q.rcw);

    // Input stage; buffers off in power-down so only CKE is seen
    d.cke = pins.cke;
    if (lowPower) begin
      d.csN = 1'b1;
    end else begin
      d.csN = pins.csN;
      d.rcw = {pins.rasN, pins.casN, pins.weN};
      d.ba = pins.ba;
      d.addr = pins.addr;
      d.dqm = pins.dqm;
      d.dqIn = pins.dqCtrl;
    end

    case (q.pwr)
      PWR_RUN: begin
        if (!q.cke) begin
          if (q.burstOn) begin
            d.pwr = PWR_SUSPEND;
          end else if (q.rowOpen == '0) begin
            if (cmd == CMD_REF) begin
              d.pwr = PWR_SELF_REF;
            end else if (cmd == CMD_BST) begin
              d.pwr = PWR_DEEP_PD;
            end else begin
              d.pwr = PWR_PDN_PRE;
            end
          end else begin
            d.pwr = PWR_PDN_ACT;
          end
        end else begin
          case (cmd)
            CMD_ACT: begin
              d.rowOpen[q.ba] = 1'b1;
              d.rowAddr[q.ba] = q.addr;
            end
            CMD_READ, CMD_WRITE: begin
              if (q.rowOpen[q.ba]) begin
                opGo = 1'b1;
                opRead = (cmd == CMD_READ);
                opBank = q.ba;
                opCol = q.addr[COL_W-1:0];
                d.burstRead = opRead;
                d.burstBank = q.ba;
                d.burstAp = q.addr[AP_BIT];
                d.burstCol = q.addr[COL_W-1:0];
                d.burstLeft = burst_rest(q.modeReg[BL_LSB +: 3]);
                d.burstOn = (d.burstLeft != '0);
                if (!d.burstOn && d.burstAp) begin
                  d.rowOpen[q.ba] = 1'b0;
                end
              end
            end
            CMD_PRE: begin
              if (q.addr[AP_BIT]) begin
                d.rowOpen = '0;
              end else begin
                d.rowOpen[q.ba] = 1'b0;
              end
              if (q.addr[AP_BIT] || q.ba == q.burstBank) begin
                d.burstOn = 1'b0;
              end
            end
            CMD_LMR: begin
              if (q.rowOpen == '0) begin
                d.modeReg = q.addr;
              end
            end
            CMD_BST: d.burstOn = 1'b0;
            default: d.burstOn = q.burstOn;
          endcase
          // Burst counter steps on every edge not taken by a new access, a burst stop or a precharge
          if (!opGo && q.burstOn && cmd != CMD_BST && cmd != CMD_PRE) begin
            opGo = 1'b1;
            opRead = q.burstRead;
            opCol = q.burstCol + 1'b1;
            d.burstCol = opCol;
            d.burstLeft = q.burstLeft - 1'b1;
            if (q.burstLeft == COL_W'(1)) begin
              d.burstOn = 1'b0;
              if (q.burstAp) begin
                d.rowOpen[q.burstBank] = 1'b0;
              end
            end
          end
        end
      end
      PWR_SUSPEND: begin
        if (q.cke) begin
          d.pwr = PWR_RUN;
        end
      end
      PWR_DEEP_PD: begin
        d.rowOpen = '0;
        if (q.cke) begin
          d.pwr = PWR_RUN;
        end
      end
      default: begin
        if (q.cke) begin
          d.pwr = PWR_RUN;
        end
      end
    endcase

    // Read pipeline and output registers freeze while suspended
    if (q.pwr != PWR_SUSPEND) begin
      d.pipeValid = {1'b0, q.pipeValid[2:1]};
      d.pipeData = {{DQ_W{1'b0}}, q.pipeData[2:1]};
      if (opGo && opRead) begin
        // CAS latency two enters nearest the pins
        if (q.modeReg[CL_LSB +: 3] == CL_2) begin
          d.pipeValid[0] = 1'b1;
          d.pipeData[0] = memRd;
        end else begin
          d.pipeValid[1] = 1'b1;
          d.pipeData[1] = memRd;
        end
      end
      d.dqmDly = q.dqm;
      d.dqOut = q.pipeData[0];
      for (int i = 0; i < LANES; i++) begin
        d.dqOeN[i] = !(q.pipeValid[0] && !q.dqmDly[i]);
      end
    end
  end

  assign opIdx = mem_index(opBank, q.rowAddr[opBank], opCol);
  assign memRd = mem[opIdx];

  // ==========================================================
  // Storage, one byte lane per generated block
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      always_ff @(posedge sys_clk) begin
        if (opGo && !opRead && !q.dqm[gl]) begin
          mem[opIdx][gl*8 +: 8] <= q.dqIn[gl*8 +: 8];
        end
      end
    end
  endgenerate

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cke <= 1'b1;
      q.csN <= 1'b1;
      q.rcw <= PIN_NOP;
      q.pwr <= PWR_RUN;
      q.dqOeN <= '1;
    end else begin
      q <= d;
    end
  end

  assign pins.dqMem = q.dqOut;
  assign pins.dqMemOeN = q.dqOeN;
  assign powerState = q.pwr;
  assign openBanks = q.rowOpen;

endmodule // sdr_mem_end
`default_nettype wire

// >>> dv/sdr_pin_chk.sv
/* Assertions on the pin link between the two ends.
   Assumes one sys_clk and the link signals as plain inputs. */
`timescale 1ns/100ps
`default_nettype none
module sdr_pin_chk
  import sdr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] dqm,
  input wire logic dqCtrlOeN,
  input wire logic [LANES-1:0] dqMemOeN
);
  // ==========================================
  // Command sequences
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] code;
  assign code = {rasN, casN, weN};
  sequence s_act; cke && !csN && code == PIN_ACT; endsequence
  sequence s_rd; cke && !csN && code == PIN_READ; endsequence
  sequence s_wr; cke && !csN && code == PIN_WRITE; endsequence
  sequence s_rw; cke && !csN && code[2:1] == 2'h2; endsequence
  // ==========================================
  // Link properties
  chk_no_nop_sel: assert property (!csN |-> code != PIN_NOP)
    else $error("selected cycle carries no command");
  chk_act_gap: assert property (s_act |=> !(!csN && code[2:1] == 2'h2))
    else $error("access right after activate");
  chk_rw_autopre: assert property (s_rw |-> addr[AP_BIT])
    else $error("access without autoprecharge");
  chk_pre_all: assert property (cke && !csN && code == PIN_PRE |-> addr[AP_BIT])
    else $error("precharge not all banks");
  chk_lmr_opcode: assert property (cke && !csN && code == PIN_LMR |-> addr == CTRL_MODE_WORD)
    else $error("mode op-code wrong");
  chk_wr_drive: assert property (s_wr |-> !dqCtrlOeN)
    else $error("write without data drive");
  chk_rd_lanes: assert property (s_rd ##0 dqm == 4'h0 |-> ##[2:4] dqMemOeN == 4'h0)
    else $error("read lanes not driven");
  chk_no_clash: assert property (!dqCtrlOeN |-> dqMemOeN == 4'hF)
    else $error("both ends drive data");
  chk_rd_one_word: assert property (dqMemOeN == 4'h0 |=> dqMemOeN == 4'hF)
    else $error("read word held too long");
endmodule // sdr_pin_chk
`default_nettype wire

// >>> dv/sdram_pin_command_interface_test.sv
/* Bench joining both ends, driving the user side with random traffic.
   Assumes the design files compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_command_interface_test;
  import sdr_pkg::*;
  logic sys_clk, rst_n, sleepReq, cmdValid, cmdReady, cmdWrite, wrValid, wrReady, rdValid, initDone, ok;
  logic [BA_W-1:0] cmdBank;
  logic [ADDR_W-1:0] cmdRow;
  logic [COL_W-1:0] cmdCol;
  logic [LANES-1:0] cmdMask, openBanks;
  logic [DQ_W-1:0] wrData, rdData, seed, expMem [32];
  logic [ADDR_W-1:0] rowA [32];
  logic [COL_W-1:0] colA [32];
  logic [2:0] powerState;
  int n_errors, check_count, cycles, got;
  sdr_pin_if pinsIf();
  sdr_mem_end sdr_mem_end_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pinsIf.mem),
    .powerState(powerState), .openBanks(openBanks));
  sdr_ctrl_end sdr_ctrl_end_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pinsIf.ctrl),
    .sleepReq(sleepReq), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
    .cmdBank(cmdBank), .cmdRow(cmdRow), .cmdCol(cmdCol), .cmdMask(cmdMask), .wrValid(wrValid),
    .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData), .initDone(initDone));
  sdr_pin_chk sdr_pin_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cke(pinsIf.cke), .csN(pinsIf.csN),
    .rasN(pinsIf.rasN), .casN(pinsIf.casN), .weN(pinsIf.weN), .addr(pinsIf.addr), .dqm(pinsIf.dqm),
    .dqCtrlOeN(pinsIf.dqCtrlOeN), .dqMemOeN(pinsIf.dqMemOeN));
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Masked lanes keep the old byte
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] m);
    logic [31:0] r;
    for (int l = 0; l < 4; l++) r[8*l +: 8] = m[l] ? old[8*l +: 8] : nw[8*l +: 8];
    return r;
  endfunction
  task automatic tick();
    @(posedge sys_clk);
    #5;
  endtask
  task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Ready seen off the edge is the value the next edge samples
  task automatic push(input logic [31:0] d);
    wrValid = 1'b1;
    wrData = d;
    ok = wrReady;
    tick();
  endtask
  task automatic do_cmd(input logic wr, input int i, input logic [3:0] m);
    cmdWrite = wr;
    cmdBank = 2'(i);
    cmdRow = rowA[i];
    cmdCol = colA[i];
    cmdMask = m;
    cmdValid = 1'b1;
    ok = 1'b0;
    for (int k = 0; k < 40 && !ok; k++) begin
      ok = cmdReady;
      tick();
    end
    cmdValid = 1'b0;
    ok = wr;
    for (int k = 0; k < 20 && !ok; k++) begin
      ok = rdValid;
      if (!ok) tick();
    end
    if (!wr) check_vec("read word", expMem[i], rdData);
    for (int k = 0; k < 20 && !cmdReady; k++) tick();
  endtask
  // ==========================================
  // Clock, timeout, sequence
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {rst_n, sleepReq, cmdValid, cmdWrite, wrValid, cmdBank, cmdRow, cmdCol, cmdMask, wrData} = '0;
    seed = 32'hEE2F;
    repeat (8) @(posedge sys_clk);
    #5 rst_n = 1'b1;
    // Fill the FIFO until it refuses, while init runs
    for (int i = 0; i < 34; i++) begin
      seed = lfsr(seed);
      push(seed);
      if (ok && got < 32) expMem[got] = seed;
      if (ok) got++;
    end
    wrValid = 1'b0;
    check_vec("fifo words", 32'(FIFO_DEPTH), 32'(got));
    for (int k = 0; k < 2200 && !initDone; k++) tick();
    check_vec("init done", 32'h1, {31'h0, initDone});
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      rowA[i] = (i == 31) ? 13'h1FFF : {seed[11:0], i[2]};
      colA[i] = (i == 31) ? 9'h1FF : {seed[15:12], 3'h0, i[4:3]};
    end
    for (int i = 0; i < 32; i++) do_cmd(1'b1, i, 4'h0);
    check_vec("open banks", 32'h0, {28'h0, openBanks});
    // Write offered with the FIFO drained is held off
    cmdWrite = 1'b1;
    cmdValid = 1'b1;
    repeat (10) tick();
    check_vec("ready on empty", 32'h1, {31'h0, cmdReady});
    cmdValid = 1'b0;
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      push(seed);
      wrValid = 1'b0;
      tick();
      tick();
      do_cmd(1'b1, i, (i == 1) ? 4'hF : (i == 2) ? 4'h0 : seed[7:4]);
      expMem[i] = merge(expMem[i], seed, (i == 1) ? 4'hF : (i == 2) ? 4'h0 : seed[7:4]);
    end
    sleepReq = 1'b1;
    repeat (10) tick();
    check_vec("power down", 32'(PWR_PDN_PRE), 32'(powerState));
    sleepReq = 1'b0;
    repeat (10) tick();
    check_vec("power run", 32'(PWR_RUN), 32'(powerState));
    for (int i = 0; i < 32; i++) do_cmd(1'b0, i, 4'h0);
    close_out();
  end
endmodule // sdram_pin_command_interface_test
`default_nettype wire
